// file: src/atc_pkg.sv
// Constants, types and state codes of the threshold alert comparator
//----------------------------------------------------------------------
// Operation
// R1: Config bit 4 picks traditional comparison at 0 (reset) or window comparison at 1.
// R2: Config bit 3 sets the alert level: 0 asserts low (reset), 1 asserts high.
// R3: With the hold bit at 0 (reset) the alert drops on a result below the lower limit (traditional) or back inside the limits (window).
// R4: With the hold bit at 1 the alert stays until the conversion result is read or an alert response wins.
// R5: On an alert response an asserting device sends its own address and the lowest address wins.
// R6: Run-length field 11 (reset) disables the comparator and floats the alert pin.
// R7: Run-length 00, 01, 10 enable the comparator and assert after 1, 2 or 4 successive exceeding results.
// R8: Lower and upper limits are 16-bit two's complement registers reset to 8000h and 7FFFh.
// R9: Upper limit MSB 1 with lower limit MSB 0 turns the pin into a ready signal (status or pulse).
// R10: Software keeps the upper limit strictly above the lower limit for comparator use.
// R11: Traditional style trips above the upper limit and clears below the lower; window trips outside.
//----------------------------------------------------------------------
package atc_pkg;

  // Register pointer codes
  localparam logic [1:0] PTR_CONV = 2'h0;
  localparam logic [1:0] PTR_CFG  = 2'h1;
  localparam logic [1:0] PTR_LO   = 2'h2;
  localparam logic [1:0] PTR_HI   = 2'h3;

  // Reset values
  localparam logic [15:0] CFG_RESET  = 16'h8583;
  localparam logic [15:0] LO_RESET   = 16'h8000;
  localparam logic [15:0] HI_RESET   = 16'h7fff;
  localparam logic [15:0] CONV_RESET = 16'h0000;

  // Field positions of converter_config
  localparam int CFG_STATUS_BIT = 15;
  localparam int CFG_MODE_BIT   = 8;
  localparam int CFG_WIN_BIT    = 4;
  localparam int CFG_LEVEL_BIT  = 3;
  localparam int CFG_HOLD_BIT   = 2;
  localparam int CFG_RUN_LSB    = 0;

  // Run-length codes
  localparam logic [1:0] RUN_ONE  = 2'h0;
  localparam logic [1:0] RUN_TWO  = 2'h1;
  localparam logic [1:0] RUN_FOUR = 2'h2;
  localparam logic [1:0] RUN_OFF  = 2'h3;

  // Shared alert response address of the bus
  localparam logic [6:0] ALERT_RESP_ADDR = 7'h0c;

  // Timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int RDY_PULSE_NS  = 40;
  localparam int RDY_PULSE_CYC = (RDY_PULSE_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_ACK  = 6'h04,
    ST_RX   = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } atc_bus_state_e;

endpackage

// file: src/atc_pin_sync.sv
// Two-stage pin synchroniser with edge detection
module atc_pin_sync (
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic pin,
  output logic      level,
  output logic      rise,
  output logic      fall
);

  logic stage1;
  logic stage2;
  logic stage3;

  // Lines idle high, so reset to high avoids a false edge
  always_ff @(posedge clk) begin
    if (reset) begin
      stage1 <= 1'b1;
      stage2 <= 1'b1;
      stage3 <= 1'b1;
    end else begin
      stage1 <= pin;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  assign level = stage2;
  assign rise  = stage2 & ~stage3;
  assign fall  = ~stage2 & stage3;

endmodule // atc_pin_sync

// file: src/atc_alert_comparator.sv
// Two-wire register port and threshold alert comparator
module atc_alert_comparator
  import atc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input  wire logic        clk,
  input  wire logic        reset,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic [15:0] result_data,
  input  wire logic        result_valid,
  input  wire logic        conv_busy,
  output logic             conv_start,
  output logic [15:0]      converter_config,
  output logic             alert_out,
  output logic             alert_oe
);

  //--------------------------------------------------------------------
  // Pin synchronisers
  //--------------------------------------------------------------------
  logic scl_s;
  logic scl_rise;
  logic scl_fall;
  logic sda_s;
  logic sda_rise;
  logic sda_fall;

  atc_pin_sync u_scl_sync (
    .clk   (clk),
    .reset (reset),
    .pin   (scl_in),
    .level (scl_s),
    .rise  (scl_rise),
    .fall  (scl_fall)
  );

  atc_pin_sync u_sda_sync (
    .clk   (clk),
    .reset (reset),
    .pin   (sda_in),
    .level (sda_s),
    .rise  (sda_rise),
    .fall  (sda_fall)
  );

  //--------------------------------------------------------------------
  // Bus state
  //--------------------------------------------------------------------
  atc_bus_state_e state,     next_state;
  logic [7:0]     shift,     next_shift;
  logic [3:0]     bitc,      next_bitc;
  logic [1:0]     byte_idx,  next_byte_idx;
  logic           rw,        next_rw;
  logic           resp,      next_resp;
  logic [1:0]     ptr,       next_ptr;
  logic [15:0]    rd_word,   next_rd_word;
  logic [7:0]     wr_hi,     next_wr_hi;
  logic           sda_low,   next_sda_low;
  logic [15:0]    cfg,       next_cfg;
  logic [15:0]    lower_limit, next_lower_limit;
  logic [15:0]    upper_limit, next_upper_limit;
  logic           start_q,   next_start_q;
  logic           clear_req;

  // Comparator state
  logic [15:0]    conv,      next_conv;
  logic [2:0]     run_cnt,   next_run_cnt;
  logic           alert_act, next_alert_act;
  logic [7:0]     rdy_cnt,   next_rdy_cnt;
  logic           alert_q,   next_alert_q;
  logic           alert_oe_q, next_alert_oe_q;

  logic           bus_start;
  logic           bus_stop;
  logic [15:0]    status_word;
  logic [15:0]    read_word;

  // Start and stop are data edges while the clock line is high
  assign bus_start = sda_fall & scl_s;
  assign bus_stop  = sda_rise & scl_s;

  assign status_word = {~conv_busy, cfg[14:0]};

  always_comb begin
    case (ptr)
      PTR_CONV: read_word = conv;
      PTR_CFG:  read_word = status_word;
      PTR_LO:   read_word = lower_limit;
      default:  read_word = upper_limit;
    endcase
  end

  //--------------------------------------------------------------------
  // Bus next-state logic
  //--------------------------------------------------------------------
  always_comb begin
    logic [7:0] tx_byte;
    tx_byte          = 8'h00;
    next_state       = state;
    next_shift       = shift;
    next_bitc        = bitc;
    next_byte_idx    = byte_idx;
    next_rw          = rw;
    next_resp        = resp;
    next_ptr         = ptr;
    next_rd_word     = rd_word;
    next_wr_hi       = wr_hi;
    next_sda_low     = sda_low;
    next_cfg         = cfg;
    next_lower_limit = lower_limit;
    next_upper_limit = upper_limit;
    next_start_q     = 1'b0;
    clear_req        = 1'b0;
    if (bus_start) begin
      next_state    = ST_ADDR;
      next_bitc     = 4'h0;
      next_byte_idx = 2'h0;
      next_sda_low  = 1'b0;
    end else if (bus_stop) begin
      next_state   = ST_IDLE;
      next_sda_low = 1'b0;
    end else begin
      case (state)
        ST_ADDR: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bitc  = bitc + 4'h1;
          end else if (scl_fall && bitc == 4'h8) begin
            next_bitc = 4'h0;
            if (shift[7:1] == DEV_ADDR) begin
              next_state   = ST_ACK;
              next_sda_low = 1'b1;
              next_rw      = shift[0];
              next_resp    = 1'b0;
              next_rd_word = read_word;
              if (shift[0] && ptr == PTR_CONV) begin
                clear_req = 1'b1; // R4
              end
            end else if (shift[7:1] == ALERT_RESP_ADDR && shift[0]
                         && alert_act) begin
              next_state   = ST_ACK; // R5
              next_sda_low = 1'b1;
              next_rw      = 1'b1;
              next_resp    = 1'b1;
            end else begin
              next_state = ST_IDLE;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_bitc = 4'h0;
            if (rw) begin
              if (resp) begin
                tx_byte = {DEV_ADDR, 1'b0}; // R5
              end else if (byte_idx == 2'h0) begin
                tx_byte = rd_word[15:8];
              end else begin
                tx_byte = rd_word[7:0];
              end
              next_shift   = tx_byte;
              next_sda_low = ~tx_byte[7];
              next_state   = ST_TX;
            end else begin
              next_sda_low = 1'b0;
              next_state   = ST_RX;
            end
          end
        end
        ST_RX: begin
          if (scl_rise) begin
            next_shift = {shift[6:0], sda_s};
            next_bitc  = bitc + 4'h1;
          end else if (scl_fall && bitc == 4'h8) begin
            next_bitc    = 4'h0;
            next_sda_low = 1'b1;
            next_state   = ST_ACK;
            if (byte_idx != 2'h3) begin
              next_byte_idx = byte_idx + 2'h1;
            end
            case (byte_idx)
              2'h0: next_ptr   = shift[1:0];
              2'h1: next_wr_hi = shift;
              2'h2: begin
                case (ptr)
                  PTR_CFG: begin
                    next_cfg = {wr_hi, shift}; // R1
                    // Status bit starts a conversion only when idle
                    if (wr_hi[7] && !conv_busy) begin
                      next_start_q = 1'b1;
                    end
                  end
                  PTR_LO:  next_lower_limit = {wr_hi, shift}; // R8
                  PTR_HI:  next_upper_limit = {wr_hi, shift}; // R8
                  default: next_wr_hi = wr_hi;
                endcase
              end
              default: next_wr_hi = wr_hi;
            endcase
          end
        end
        ST_TX: begin
          if (scl_rise) begin
            next_bitc = bitc + 4'h1;
            // Released a one but saw a zero: a lower address wins
            if (resp && shift[7] && !sda_s) begin
              next_state   = ST_IDLE; // R5
              next_sda_low = 1'b0;
            end
          end else if (scl_fall) begin
            if (bitc == 4'h8) begin
              next_sda_low = 1'b0;
              next_state   = ST_MACK;
              if (resp) begin
                clear_req = 1'b1; // R4
              end
            end else begin
              next_shift   = {shift[6:0], 1'b0};
              next_sda_low = ~shift[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise && sda_s) begin
            next_state = ST_IDLE;
          end else if (scl_fall) begin
            next_bitc     = 4'h0;
            next_byte_idx = byte_idx + 2'h1;
            tx_byte       = (byte_idx == 2'h0) ? rd_word[7:0]
                                               : rd_word[15:8];
            next_shift    = tx_byte;
            next_sda_low  = ~tx_byte[7];
            next_state    = ST_TX;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state       <= ST_IDLE;
      shift       <= 8'h00;
      bitc        <= 4'h0;
      byte_idx    <= 2'h0;
      rw          <= 1'b0;
      resp        <= 1'b0;
      ptr         <= PTR_CONV;
      rd_word     <= 16'h0000;
      wr_hi       <= 8'h00;
      sda_low     <= 1'b0;
      cfg         <= CFG_RESET;
      lower_limit <= LO_RESET;
      upper_limit <= HI_RESET;
      start_q     <= 1'b0;
    end else begin
      state       <= next_state;
      shift       <= next_shift;
      bitc        <= next_bitc;
      byte_idx    <= next_byte_idx;
      rw          <= next_rw;
      resp        <= next_resp;
      ptr         <= next_ptr;
      rd_word     <= next_rd_word;
      wr_hi       <= next_wr_hi;
      sda_low     <= next_sda_low;
      cfg         <= next_cfg;
      lower_limit <= next_lower_limit;
      upper_limit <= next_upper_limit;
      start_q     <= next_start_q;
    end
  end

  //--------------------------------------------------------------------
  // Comparator next-state logic
  //--------------------------------------------------------------------
  always_comb begin
    logic       over;
    logic       under;
    logic       exceed;
    logic       rdy_mode;
    logic       asserted;
    logic [2:0] need;
    logic [1:0] run;
    need     = 3'h4;
    asserted = 1'b0;
    run      = cfg[CFG_RUN_LSB +: 2];
    over     = $signed(result_data) > $signed(upper_limit);
    under    = $signed(result_data) < $signed(lower_limit);
    exceed   = cfg[CFG_WIN_BIT] ? (over | under) : over; // R11
    rdy_mode = upper_limit[15] & ~lower_limit[15]; // R9
    case (run)
      RUN_ONE: need = 3'h1; // R7
      RUN_TWO: need = 3'h2; // R7
      default: need = 3'h4; // R7
    endcase
    next_conv      = result_valid ? result_data : conv;
    next_run_cnt   = run_cnt;
    next_alert_act = alert_act;
    next_rdy_cnt   = rdy_cnt;
    if (run == RUN_OFF) begin
      next_run_cnt   = 3'h0; // R6
      next_alert_act = 1'b0;
      next_rdy_cnt   = 8'h00;
    end else if (rdy_mode) begin
      next_alert_act = 1'b0;
      if (result_valid) begin
        next_rdy_cnt = 8'(RDY_PULSE_CYC); // R9
      end else if (rdy_cnt != 8'h00) begin
        next_rdy_cnt = rdy_cnt - 8'h01;
      end
      asserted = cfg[CFG_MODE_BIT] ? ~conv_busy : (rdy_cnt != 8'h00); // R9
    end else begin
      // Clear first so that a trip in the same cycle wins
      if (clear_req && cfg[CFG_HOLD_BIT]) begin
        next_alert_act = 1'b0; // R4
      end
      if (result_valid) begin
        if (exceed) begin
          if (run_cnt < need) begin
            next_run_cnt = run_cnt + 3'h1;
          end
          if (run_cnt + 3'h1 >= need) begin
            next_alert_act = 1'b1; // R7
          end
        end else begin
          next_run_cnt = 3'h0;
          if (!cfg[CFG_HOLD_BIT]
              && (cfg[CFG_WIN_BIT] || under)) begin
            next_alert_act = 1'b0; // R3
          end
        end
      end
      asserted = alert_act;
    end
    next_alert_q    = cfg[CFG_LEVEL_BIT] ? asserted : ~asserted; // R2
    next_alert_oe_q = (run != RUN_OFF); // R6
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      conv       <= CONV_RESET;
      run_cnt    <= 3'h0;
      alert_act  <= 1'b0;
      rdy_cnt    <= 8'h00;
      alert_q    <= 1'b1;
      alert_oe_q <= 1'b0;
    end else begin
      conv       <= next_conv;
      run_cnt    <= next_run_cnt;
      alert_act  <= next_alert_act;
      rdy_cnt    <= next_rdy_cnt;
      alert_q    <= next_alert_q;
      alert_oe_q <= next_alert_oe_q;
    end
  end

  // Open-drain data line: only ever pulls low
  assign sda_out          = 1'b0;
  assign sda_oe           = sda_low;
  assign conv_start       = start_q;
  assign converter_config = cfg;
  assign alert_out        = alert_q;
  assign alert_oe         = alert_oe_q;

endmodule // atc_alert_comparator

// file: dv/atc_alert_comparator_chk.sv
// Port-level assertions of the threshold alert comparator
//--------------------
// Checker
//--------------------
module atc_alert_comparator_chk
  import atc_pkg::*;
#(
  parameter logic [6:0] DEV_ADDR = 7'h2a
) (
  input wire logic        clk,
  input wire logic        reset,
  input wire logic        scl_in,
  input wire logic        sda_in,
  input wire logic        sda_out,
  input wire logic        sda_oe,
  input wire logic [15:0] result_data,
  input wire logic        result_valid,
  input wire logic        conv_busy,
  input wire logic        conv_start,
  input wire logic [15:0] converter_config,
  input wire logic        alert_out,
  input wire logic        alert_oe
);
  timeunit 1ns;
  timeprecision 1ps;
  logic       act;
  logic       run_ok;
  logic [3:0] hi_cnt;
  logic [3:0] next_hi_cnt;
  logic [2:0] rv_cnt;
  logic [2:0] next_rv_cnt;

  assign act = alert_oe && (alert_out == converter_config[3]);

  // Results seen since switch-off bound the run; never an exact count
  always_comb begin
    next_hi_cnt = (hi_cnt == 4'hf) ? hi_cnt : hi_cnt + 4'h1;
    if (!scl_in) begin
      next_hi_cnt = 4'h0;
    end
    next_rv_cnt = rv_cnt;
    if (result_valid && rv_cnt != 3'h7) begin
      next_rv_cnt = rv_cnt + 3'h1;
    end
    if (converter_config[1:0] == RUN_OFF) begin
      next_rv_cnt = 3'h0;
    end
    case (converter_config[1:0])
      RUN_TWO:  run_ok = rv_cnt >= 3'h2;
      RUN_FOUR: run_ok = rv_cnt >= 3'h4;
      default:  run_ok = rv_cnt >= 3'h1;
    endcase
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      hi_cnt <= 4'h0;
      rv_cnt <= 3'h0;
    end else begin
      hi_cnt <= next_hi_cnt;
      rv_cnt <= next_rv_cnt;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  sequence s_quiet;
    ($stable(converter_config) && $stable(conv_busy))[*3];
  endsequence

  a_reset_quiet: assert property (
    $fell(reset) |-> converter_config == CFG_RESET && !alert_oe
  ) else $error("alert pin not idle after reset");
  a_float_off: assert property (
    (converter_config[1:0] == RUN_OFF)[*2] |-> !alert_oe
  ) else $error("alert pin driven while switched off");
  a_drive_on: assert property (
    (converter_config[1:0] != RUN_OFF)[*2] |-> alert_oe
  ) else $error("alert pin floating while enabled");
  a_level_flip: assert property (
    $changed(converter_config[3]) && $stable(converter_config[1:0])
    && alert_oe |-> ##2 alert_out != $past(alert_out, 3)
  ) else $error("alert level ignores polarity");
  a_trip_cause: assert property (
    s_quiet ##0 $rose(act) |-> $past(result_valid, 2) && run_ok
  ) else $error("alert raised without enough results");
  a_free_drop: assert property (
    s_quiet ##0 ($fell(act) && !converter_config[2])
    |-> $past(result_valid, 2)
  ) else $error("unheld alert dropped without result");
  a_hold_keep: assert property (
    act && converter_config[2] && hi_cnt == 4'hf |=> act
  ) else $error("held alert dropped with bus idle");
  a_start_pulse: assert property (
    conv_start |-> !$past(conv_busy) ##1 !conv_start
  ) else $error("conversion start not a single pulse");
endmodule // atc_alert_comparator_chk

bind atc_alert_comparator atc_alert_comparator_chk #(
  .DEV_ADDR(DEV_ADDR)
) chk_inst (
  .clk(clk), .reset(reset), .scl_in(scl_in), .sda_in(sda_in),
  .sda_out(sda_out), .sda_oe(sda_oe), .result_data(result_data),
  .result_valid(result_valid), .conv_busy(conv_busy),
  .conv_start(conv_start), .converter_config(converter_config),
  .alert_out(alert_out), .alert_oe(alert_oe)
);

// file: dv/atc_i2c_host.sv
// Bus controller model reaching the registers over the two-wire port
//--------------------
// Controller
//--------------------
module atc_i2c_host #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic clk,
  input  wire logic dev_oe,
  output logic      scl,
  output logic      sda
);
  timeunit 1ns;
  timeprecision 1ps;
  logic drv_low = 1'b0;

  // Pull-up: a released line reads high, never the last driven value
  assign sda = ~(drv_low | dev_oe);

  initial begin
    scl = 1'b1;
  end

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Data moves only while the clock is low; 48 ns per bit
  task automatic bit_io(input logic b, output logic r);
    wt(3);
    drv_low <= ~b;
    wt(3);
    scl <= 1'b1;
    wt(3);
    r = sda;
    wt(3);
    scl <= 1'b0;
  endtask

  task automatic start();
    wt(6);
    drv_low <= 1'b1;
    wt(6);
    scl <= 1'b0;
  endtask

  task automatic stop();
    wt(3);
    drv_low <= 1'b1;
    wt(3);
    scl <= 1'b1;
    wt(6);
    drv_low <= 1'b0;
    wt(6);
    #1;
  endtask

  task automatic xbyte(input logic [7:0] d, input logic a,
                       output logic [7:0] q, output logic n);
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], q[i]);
    end
    bit_io(a, n);
  endtask

  task automatic wr(input logic [1:0] p, input logic [15:0] v);
    logic [7:0] q;
    logic       n;
    start();
    xbyte({ADDR, 1'b0}, 1'b1, q, n);
    xbyte({6'h00, p}, 1'b1, q, n);
    xbyte(v[15:8], 1'b1, q, n);
    xbyte(v[7:0], 1'b1, q, n);
    stop();
  endtask

  // Alert response uses the shared address and skips the pointer
  task automatic rd(input logic [6:0] a, input logic [1:0] p,
                    input logic two, output logic [15:0] v,
                    output logic n);
    logic [7:0] q;
    v = 16'hffff;
    if (a == ADDR) begin
      start();
      xbyte({ADDR, 1'b0}, 1'b1, q, n);
      xbyte({6'h00, p}, 1'b1, q, n);
      stop();
    end
    start();
    xbyte({a, 1'b1}, 1'b1, q, n);
    if (!n) begin
      xbyte(8'hff, ~two, v[15:8], q[0]);
    end
    if (!n && two) begin
      xbyte(8'hff, 1'b1, v[7:0], q[0]);
    end
    stop();
  endtask
endmodule // atc_i2c_host

// file: dv/atc_alert_comparator_tb.sv
// Self-checking bench of the threshold alert comparator
//--------------------
// Bench
//--------------------
module atc_alert_comparator_tb
  import atc_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] ADDR = 7'h2a;
  typedef struct packed {
    logic [7:0]  c;
    logic [2:0]  k;
    logic [15:0] r;
    logic        a;
  } atc_row_s;
  localparam atc_row_s ROWS [12] = '{
    '{8'h00, 3'h1, 16'h0300, 1'b1}, '{8'h08, 3'h1, 16'h0300, 1'b1},
    '{8'h01, 3'h1, 16'h0300, 1'b0}, '{8'h01, 3'h2, 16'h0300, 1'b1},
    '{8'h02, 3'h3, 16'h0300, 1'b0}, '{8'h02, 3'h4, 16'h0300, 1'b1},
    '{8'h00, 3'h1, 16'h0150, 1'b0}, '{8'h10, 3'h1, 16'hff00, 1'b1},
    '{8'h10, 3'h1, 16'h0150, 1'b0}, '{8'h18, 3'h2, 16'h0250, 1'b1},
    '{8'h03, 3'h4, 16'h0300, 1'b0}, '{8'h00, 3'h1, 16'hff00, 1'b0}};
  logic        clk, reset, result_valid, conv_busy, n;
  logic        scl, sda, sda_out, sda_oe, conv_start;
  logic        alert_out, alert_oe;
  logic [15:0] result_data, conf, v;
  logic [15:0] starts = 16'h0000;
  int          mismatches = 0;
  int          samples_checked = 0;

  atc_alert_comparator #(.DEV_ADDR(ADDR)) atc_alert_comparator_inst (
    .clk(clk), .reset(reset), .scl_in(scl), .sda_in(sda),
    .sda_out(sda_out), .sda_oe(sda_oe), .result_data(result_data),
    .result_valid(result_valid), .conv_busy(conv_busy),
    .conv_start(conv_start), .converter_config(conf),
    .alert_out(alert_out), .alert_oe(alert_oe));
  atc_i2c_host #(.ADDR(ADDR)) host (
    .clk(clk), .dev_oe(sda_oe), .scl(scl), .sda(sda));

  // Conversion starts seen on the output, one per accepted request
  always @(posedge clk) begin
    if (conv_start === 1'b1) begin
      starts <= starts + 16'h0001;
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask

  task automatic chk_bit(input logic got, input logic exp);
    chk_word({15'h0000, got}, {15'h0000, exp});
  endtask

  task automatic pulse(input logic [15:0] r, input int k);
    @(posedge clk);
    repeat (k) begin
      result_data <= r;
      result_valid <= 1'b1;
      @(posedge clk);
      result_valid <= 1'b0;
      @(posedge clk);
    end
    repeat (3) @(posedge clk);
    #1;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  // About 40 transfers of 500 clocks each, with ample margin
  initial begin
    repeat (60000) @(posedge clk);
    mismatches++;
    results();
  end

  initial begin
    reset = 1'b1;
    result_data = 16'h0000;
    result_valid = 1'b0;
    conv_busy = 1'b0;
    repeat (10) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk_word(conf, 16'h8583);
    chk_bit(alert_oe, 1'b0);
    host.rd(ADDR, 2'h2, 1'b1, v, n);
    chk_word(v, 16'h8000);
    host.rd(ADDR, 2'h3, 1'b1, v, n);
    chk_word(v, 16'h7fff);
    host.wr(2'h2, 16'h0100);
    host.wr(2'h3, 16'h0200);
    host.rd(ADDR, 2'h2, 1'b1, v, n);
    chk_word(v, 16'h0100);
    foreach (ROWS[i]) begin
      // Switching off first clears any run left by the previous row
      host.wr(2'h1, 16'h8583);
      host.wr(2'h1, {8'h05, ROWS[i].c});
      pulse(ROWS[i].r, ROWS[i].k);
      chk_bit(alert_oe, ROWS[i].c[1:0] != 2'h3);
      chk_bit(alert_out, ROWS[i].a ~^ ROWS[i].c[3]);
    end
    host.wr(2'h1, 16'h0500);
    pulse(16'h0300, 1);
    chk_bit(alert_out, 1'b0);
    pulse(16'h0150, 1);
    chk_bit(alert_out, 1'b0);
    pulse(16'h0000, 1);
    chk_bit(alert_out, 1'b1);
    host.wr(2'h1, 16'h0504);
    pulse(16'h0300, 1);
    pulse(16'hff00, 4);
    chk_bit(alert_out, 1'b0);
    host.wr(2'h1, 16'h050c);
    chk_bit(alert_out, 1'b1);
    host.rd(ADDR, 2'h0, 1'b1, v, n);
    chk_word(v, 16'hff00);
    chk_bit(alert_out, 1'b0);
    pulse(16'h0300, 1);
    host.rd(7'h0c, 2'h0, 1'b0, v, n);
    chk_bit(n, 1'b0);
    chk_word({8'h00, v[15:8]}, {8'h00, ADDR, 1'b0});
    chk_bit(alert_out, 1'b0);
    host.rd(7'h0c, 2'h0, 1'b0, v, n);
    chk_bit(n, 1'b1);
    host.rd(7'h11, 2'h0, 1'b1, v, n);
    chk_bit(n, 1'b1);
    chk_bit(sda_out, 1'b0);
    // Ready use: busy first, so that entering it raises no alert
    @(posedge clk);
    conv_busy <= 1'b1;
    host.wr(2'h3, 16'h8000);
    host.wr(2'h1, 16'h8508);
    host.rd(ADDR, 2'h1, 1'b1, v, n);
    chk_word(v, 16'h0508);
    chk_bit(alert_out, 1'b0);
    @(posedge clk);
    conv_busy <= 1'b0;
    repeat (4) @(posedge clk);
    #1;
    chk_bit(alert_out, 1'b1);
    chk_word(starts, 16'h000c);
    // Reset in mid-run must restore the configuration and upper limit registers
    @(posedge clk);
    reset <= 1'b1;
    repeat (4) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    #1;
    chk_word(conf, 16'h8583);
    chk_bit(alert_oe, 1'b0);
    host.rd(ADDR, 2'h3, 1'b1, v, n);
    chk_word(v, 16'h7fff);
    results();
  end
endmodule // atc_alert_comparator_tb
